// ### hw/i2c_channel_regs.sv
`timescale 1ns/100ps
module i2c_channel_regs
    import i2c_ctl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        sda_in,
    input  wire logic        scl_in,
    input  wire logic        debug_mode,
    input  wire logic        bus_busy_in,
    input  wire logic        sending_in,
    input  wire engine_evt_t evt,
    output engine_cfg_t      cfg,
    output logic             clk_gate_on,
    output logic             irq
);

    // -----------------------------------------------------------------
    // State.
    // -----------------------------------------------------------------
    typedef enum logic { SR_IDLE, SR_BUSY } srst_state_t;

    typedef struct packed {
        logic        debug_clock_keep;
        logic [1:0]  clock_divide_sel;
        logic [1:0]  clock_origin_sel;
        logic        wide_address_sel;
        logic        general_call_reply;
        logic [6:0]  bit_rate_value;
        logic [9:0]  own_address_value;
        logic        master_role_sel;
        logic        nack_request;
        logic        stop_request;
        logic        start_request;
        logic        module_enable;
        srst_state_t srst_state;
        logic [3:0]  srst_cnt;
        logic [7:0]  tx_byte;
        logic [7:0]  rx_byte;
        logic [7:0]  flags;
        logic [7:0]  irq_en;
        logic [1:0]  sda_sync;
        logic [1:0]  scl_sync;
        logic [1:0]  dbg_sync;
        logic        busy;
        logic        sending;
        logic [15:0] rdata;
        logic        irq;
        logic        clk_gate_on;
        engine_cfg_t cfg;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [1:0] eff_div;
    logic       cfg_open;
    logic       in_srst;

    // -----------------------------------------------------------------
    // Next-state logic.
    // -----------------------------------------------------------------
    always_comb
    begin
        st_nxt   = st_r;
        in_srst  = (st_r.srst_state == SR_BUSY);
        cfg_open = !st_r.module_enable;

        // Pins cross in via two flops; only the second flop is read.
        st_nxt.sda_sync = {st_r.sda_sync[0], sda_in};
        st_nxt.scl_sync = {st_r.scl_sync[0], scl_in};
        st_nxt.dbg_sync = {st_r.dbg_sync[0], debug_mode};
        st_nxt.busy     = bus_busy_in;
        st_nxt.sending  = sending_in;

        // Hardware events set flags; a same-cycle write-1 loses to them.
        if (reg_wr && reg_addr == REG_STATUS)
        begin
            for (int i = FLAG_W1C_LSB; i <= FLAG_W1C_MSB; i++)
            begin
                if (reg_wdata[i])
                    st_nxt.flags[i] = 1'b0;
            end
        end
        if (reg_wr && reg_addr == REG_TX_BUF)
        begin
            st_nxt.tx_byte  = reg_wdata[7:0];
            st_nxt.flags[0] = 1'b0;
        end
        if (reg_rd && reg_addr == REG_RX_BUF)
            st_nxt.flags[1] = 1'b0;
        if (evt.rx_load)
        begin
            st_nxt.rx_byte  = evt.rx_byte;
            st_nxt.flags[1] = 1'b1;
        end
        if (evt.tx_taken)
            st_nxt.flags[0] = 1'b1;
        st_nxt.flags[7] = st_nxt.flags[7] | evt.byte_done;
        st_nxt.flags[6] = st_nxt.flags[6] | evt.gen_call;
        st_nxt.flags[5] = st_nxt.flags[5] | evt.nack_seen;
        st_nxt.flags[4] = st_nxt.flags[4] | evt.stop_event;
        st_nxt.flags[3] = st_nxt.flags[3] | evt.start_event;
        st_nxt.flags[2] = st_nxt.flags[2] | evt.fault;

        // Request bits self-clear on completion; a new write wins.
        if (evt.nack_sent)
            st_nxt.nack_request = 1'b0;
        if (evt.start_done)
            st_nxt.start_request = 1'b0;
        if (evt.stop_done)
            st_nxt.stop_request = 1'b0;

        // Register writes.
        if (reg_wr)
        begin
            case (reg_addr)
                REG_CLOCK_SELECT:
                    if (cfg_open)
                    begin
                        st_nxt.debug_clock_keep =
                            reg_wdata[CLK_DEBUG_KEEP_BIT];
                        st_nxt.clock_divide_sel =
                            reg_wdata[CLK_DIV_LSB +: 2];
                        st_nxt.clock_origin_sel =
                            reg_wdata[CLK_SRC_LSB +: 2];
                    end
                REG_ADDR_MODE:
                    if (cfg_open)
                    begin
                        st_nxt.wide_address_sel =
                            reg_wdata[MODE_WIDE_BIT];
                        st_nxt.general_call_reply =
                            reg_wdata[MODE_GCALL_BIT];
                    end
                REG_BIT_RATE:
                    if (cfg_open)
                        st_nxt.bit_rate_value = reg_wdata[6:0];
                REG_OWN_ADDR:
                    if (cfg_open)
                        st_nxt.own_address_value = reg_wdata[9:0];
                REG_CONTROL:
                begin
                    st_nxt.master_role_sel = reg_wdata[CTL_MASTER_BIT];
                    st_nxt.module_enable   = reg_wdata[CTL_ENABLE_BIT];
                    if (reg_wdata[CTL_NACK_BIT])
                        st_nxt.nack_request = 1'b1;
                    // START and STOP only take effect as a master.
                    if (reg_wdata[CTL_STOP_BIT] &&
                        reg_wdata[CTL_MASTER_BIT])
                        st_nxt.stop_request = 1'b1;
                    if (reg_wdata[CTL_START_BIT] &&
                        reg_wdata[CTL_MASTER_BIT])
                        st_nxt.start_request = 1'b1;
                    if (reg_wdata[CTL_SRST_BIT])
                    begin
                        st_nxt.srst_state = SR_BUSY;
                        st_nxt.srst_cnt   = SRST_CYCLES;
                    end
                end
                REG_IRQ_EN:
                    st_nxt.irq_en = reg_wdata[7:0];
                default:
                    st_nxt.irq_en = st_nxt.irq_en;
            endcase
        end

        // Soft reset: a fixed count of cycles clearing engine state.
        case (st_r.srst_state)
            SR_IDLE:
                st_nxt.srst_cnt = st_nxt.srst_cnt;
            SR_BUSY:
            begin
                st_nxt.flags         = 8'h00;
                st_nxt.nack_request  = 1'b0;
                st_nxt.start_request = 1'b0;
                st_nxt.stop_request  = 1'b0;
                st_nxt.srst_cnt      = st_r.srst_cnt - 4'h1;
                if (st_r.srst_cnt == 4'h1)
                    st_nxt.srst_state = SR_IDLE;
            end
            default:
                st_nxt.srst_state = SR_IDLE;
        endcase

        // Only internal and high-speed sources honour the divider.
        if (st_nxt.clock_origin_sel == SRC_INTERNAL_RC ||
            st_nxt.clock_origin_sel == SRC_HIGH_SPEED)
            eff_div = st_nxt.clock_divide_sel;
        else
            eff_div = 2'h0;

        // Clock gate: enable on, and either not debugging or kept.
        st_nxt.clk_gate_on = st_nxt.module_enable &&
            (!st_r.dbg_sync[1] || st_nxt.debug_clock_keep);

        st_nxt.cfg.run                = st_nxt.clk_gate_on;
        st_nxt.cfg.master_role_sel    = st_nxt.master_role_sel;
        st_nxt.cfg.wide_address_sel   = st_nxt.wide_address_sel;
        st_nxt.cfg.general_call_reply = st_nxt.general_call_reply;
        st_nxt.cfg.bit_rate_value     = st_nxt.bit_rate_value;
        // Narrow mode hides the upper address bits from the matcher.
        st_nxt.cfg.own_address_value  = st_nxt.wide_address_sel ?
            st_nxt.own_address_value :
            {3'h0, st_nxt.own_address_value[6:0]};
        st_nxt.cfg.clock_origin_sel   = st_nxt.clock_origin_sel;
        st_nxt.cfg.clock_divide_sel   = eff_div;
        st_nxt.cfg.nack_request       = st_nxt.nack_request;
        st_nxt.cfg.start_request      = st_nxt.start_request;
        st_nxt.cfg.stop_request       = st_nxt.stop_request;
        st_nxt.cfg.engine_reset       = st_nxt.srst_state == SR_BUSY;
        st_nxt.cfg.tx_byte            = st_nxt.tx_byte;

        st_nxt.irq = |(st_nxt.flags & st_nxt.irq_en);

        // Read data, valid the cycle after the strobe; reserved is zero.
        st_nxt.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                REG_CLOCK_SELECT:
                    st_nxt.rdata = {7'h00, st_r.debug_clock_keep, 2'h0,
                        st_r.clock_divide_sel, 2'h0,
                        st_r.clock_origin_sel};
                REG_ADDR_MODE:
                    st_nxt.rdata = {13'h0000, st_r.wide_address_sel,
                        st_r.general_call_reply, 1'b0};
                REG_BIT_RATE:
                    st_nxt.rdata = {9'h000, st_r.bit_rate_value};
                REG_OWN_ADDR:
                    st_nxt.rdata = {6'h00, st_r.own_address_value};
                REG_CONTROL:
                    st_nxt.rdata = {10'h000, st_r.master_role_sel,
                        st_r.nack_request, st_r.stop_request,
                        st_r.start_request, in_srst,
                        st_r.module_enable};
                REG_TX_BUF:
                    st_nxt.rdata = {8'h00, st_r.tx_byte};
                REG_RX_BUF:
                    st_nxt.rdata = {8'h00, st_r.rx_byte};
                REG_STATUS:
                    st_nxt.rdata = {3'h0, !st_r.sda_sync[1],
                        !st_r.scl_sync[1], st_r.busy,
                        st_r.sending, 1'b0, st_r.flags};
                REG_IRQ_EN:
                    st_nxt.rdata = {8'h00, st_r.irq_en};
                default:
                    st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // State register; clock enable freezes everything.
    // -----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_r                   <= '0;
            st_r.bit_rate_value    <= BIT_RATE_RESET;
            st_r.own_address_value <= OWN_ADDR_RESET;
            st_r.sda_sync          <= 2'h3;
            st_r.scl_sync          <= 2'h3;
            st_r.cfg.bit_rate_value <= BIT_RATE_RESET;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata   = st_r.rdata;
    assign cfg         = st_r.cfg;
    assign clk_gate_on = st_r.clk_gate_on;
    assign irq         = st_r.irq;

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------
    sequence srst_write_s;
        reg_wr && clk_en && reg_addr == REG_CONTROL &&
            reg_wdata[CTL_SRST_BIT];
    endsequence

    AST_CFG_LOCKED: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && clk_en && reg_addr == REG_BIT_RATE &&
         st_r.module_enable) |=> $stable(st_r.bit_rate_value))
        else $error("Bit rate changed while enabled.");
    AST_IRQ_MASK: assert property (@(posedge clock) disable iff (srst)
        clk_en |=> (irq == |($past(st_nxt.flags) & $past(st_nxt.irq_en))))
        else $error("Interrupt does not follow enabled flags.");
    AST_SRST_FLAGS: assert property (@(posedge clock) disable iff (srst)
        srst_write_s ##1 clk_en |=> st_r.flags == 8'h00)
        else $error("Soft reset left a flag set.");
    AST_TX_EMPTY_CLR: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && clk_en && reg_addr == REG_TX_BUF && !evt.tx_taken &&
         !in_srst) |=> !st_r.flags[0])
        else $error("Transmit-empty flag not cleared.");
    AST_RX_FULL_CLR: assert property (@(posedge clock) disable iff (srst)
        (reg_rd && clk_en && reg_addr == REG_RX_BUF && !evt.rx_load)
        |=> !st_r.flags[1])
        else $error("Receive-full flag not cleared.");
    AST_W1C_SET_WINS: assert property (@(posedge clock) disable iff (srst)
        (clk_en && evt.byte_done && !in_srst) |=> st_r.flags[7])
        else $error("Byte-done event lost.");
    AST_START_SLAVE: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && clk_en && reg_addr == REG_CONTROL &&
         !reg_wdata[CTL_MASTER_BIT] && !st_r.start_request)
        |=> !st_r.start_request)
        else $error("START taken in slave role.");
    AST_NACK_HOLD: assert property (@(posedge clock) disable iff (srst)
        (clk_en && st_r.nack_request && !evt.nack_sent && !in_srst)
        |=> st_r.nack_request)
        else $error("NACK request dropped early.");
    AST_CLK_GATE: assert property (@(posedge clock) disable iff (srst)
        (clk_en && !st_nxt.module_enable) |=> !clk_gate_on)
        else $error("Clock supplied while disabled.");

    // Soft reset runs for a fixed count of enabled cycles, then ends.
    // A second soft reset written mid-count is not covered here.
    sequence srst_run_s;
        (clk_en && in_srst) [*4];
    endsequence

    AST_SRST_BEGIN: assert property (
        @(posedge clock) disable iff (srst)
        srst_write_s |=> in_srst)
        else $error("Soft reset did not start.");
    AST_SRST_END: assert property (
        @(posedge clock) disable iff (srst)
        srst_write_s ##1 srst_run_s |=> !in_srst)
        else $error("Soft reset did not finish on time.");

    // Read data are zero outside the cycle after a read strobe.
    AST_RDATA_IDLE: assert property (
        @(posedge clock) disable iff (srst)
        (clk_en && !reg_rd) |=> reg_rdata == 16'h0000)
        else $error("Read data not zero between reads.");
    AST_RSVD_STATUS: assert property (
        @(posedge clock) disable iff (srst)
        (clk_en && reg_rd && reg_addr == REG_STATUS) |=>
            (reg_rdata[15:13] == 3'h0 && !reg_rdata[8]))
        else $error("Reserved status bits not zero.");

endmodule : i2c_channel_regs

// ### hw/i2c_ctl_pkg.sv
package i2c_ctl_pkg;

    // -----------------------------------------------------------------
    // Register indices (word offsets); byte address is index times four.
    // -----------------------------------------------------------------
    localparam logic [3:0] REG_CLOCK_SELECT = 4'h0;
    localparam logic [3:0] REG_ADDR_MODE    = 4'h1;
    localparam logic [3:0] REG_BIT_RATE     = 4'h2;
    localparam logic [3:0] REG_OWN_ADDR     = 4'h3;
    localparam logic [3:0] REG_CONTROL      = 4'h4;
    localparam logic [3:0] REG_TX_BUF       = 4'h5;
    localparam logic [3:0] REG_RX_BUF       = 4'h6;
    localparam logic [3:0] REG_STATUS       = 4'h7;
    localparam logic [3:0] REG_IRQ_EN       = 4'h8;

    // -----------------------------------------------------------------
    // Field positions.
    // -----------------------------------------------------------------
    localparam int CLK_DEBUG_KEEP_BIT  = 8;
    localparam int CLK_DIV_LSB         = 4;
    localparam int CLK_SRC_LSB         = 0;
    localparam int MODE_WIDE_BIT       = 2;
    localparam int MODE_GCALL_BIT      = 1;
    localparam int CTL_MASTER_BIT      = 5;
    localparam int CTL_NACK_BIT        = 4;
    localparam int CTL_STOP_BIT        = 3;
    localparam int CTL_START_BIT       = 2;
    localparam int CTL_SRST_BIT        = 1;
    localparam int CTL_ENABLE_BIT      = 0;
    localparam int ST_SDA_LOW_BIT      = 12;
    localparam int ST_SCL_LOW_BIT      = 11;
    localparam int ST_BUSY_BIT         = 10;
    localparam int ST_SENDING_BIT      = 9;
    localparam int FLAG_W1C_LSB        = 2;
    localparam int FLAG_W1C_MSB        = 7;

    // -----------------------------------------------------------------
    // Reset values and encodings.
    // -----------------------------------------------------------------
    localparam logic [6:0] BIT_RATE_RESET  = 7'h7F;
    localparam logic [9:0] OWN_ADDR_RESET  = 10'h000;
    localparam logic [1:0] SRC_INTERNAL_RC = 2'h0;
    localparam logic [1:0] SRC_LOW_SPEED   = 2'h1;
    localparam logic [1:0] SRC_HIGH_SPEED  = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL    = 2'h3;
    localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
    localparam logic [3:0] SRST_CYCLES     = 4'h4;

    // Events reported by the transfer engine, one cycle pulses.
    typedef struct packed {
        logic       byte_done;
        logic       gen_call;
        logic       nack_seen;
        logic       stop_event;
        logic       start_event;
        logic       fault;
        logic       rx_load;
        logic       tx_taken;
        logic [7:0] rx_byte;
        logic       nack_sent;
        logic       start_done;
        logic       stop_done;
    } engine_evt_t;

    // Settings handed to the transfer engine.
    typedef struct packed {
        logic       run;
        logic       master_role_sel;
        logic       wide_address_sel;
        logic       general_call_reply;
        logic [6:0] bit_rate_value;
        logic [9:0] own_address_value;
        logic [1:0] clock_origin_sel;
        logic [1:0] clock_divide_sel;
        logic       nack_request;
        logic       start_request;
        logic       stop_request;
        logic       engine_reset;
        logic [7:0] tx_byte;
    } engine_cfg_t;

endpackage : i2c_ctl_pkg

// ### sim/engine_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Behavioural transfer engine on the far side of the registers.
// ---------------------------------------------------------------
module engine_model
    import i2c_ctl_pkg::*;
#(
    parameter int DLY = 3
)
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire engine_cfg_t cfg,
    input  wire logic [7:0]  kick,
    input  wire logic [7:0]  rx_data,
    output engine_evt_t      evt,
    output logic             busy,
    output logic             sending
);
    int cnt;

    // Requests finish only after DLY+1 cycles, so a request bit is seen
    // pending for a while, as on a slow bus.
    always_ff @(posedge clock)
    begin
        evt <= {kick, rx_data, 3'b000};
        if (srst || cfg.engine_reset)
        begin
            cnt  <= 0;
            busy <= 1'b0;
        end
        else if (cfg.start_request || cfg.stop_request || cfg.nack_request)
        begin
            cnt <= (cnt == DLY) ? 0 : cnt + 1;
            if (cnt == DLY && cfg.start_request)
            begin
                evt.start_done  <= 1'b1;
                evt.start_event <= 1'b1;
                busy            <= 1'b1;
            end
            else if (cnt == DLY && cfg.stop_request)
            begin
                evt.stop_done  <= 1'b1;
                evt.stop_event <= 1'b1;
                busy           <= 1'b0;
            end
            else if (cnt == DLY)
                evt.nack_sent <= 1'b1;
        end
        else
            cnt <= 0;
    end

    // A master holding the bus is the sending side.
    assign sending = busy & cfg.master_role_sel;
endmodule : engine_model

// ### sim/i2c_channel_register_control_test.sv
`timescale 1ns/100ps
module i2c_channel_register_control_test
    import i2c_ctl_pkg::*;
;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        clk_en = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic        sda_in = 1'b1;
    logic        scl_in = 1'b1;
    logic        debug_mode = 1'b0;
    logic [7:0]  kick = 8'h00;
    logic [7:0]  rx_data = 8'h00;
    logic        busy;
    logic        sending;
    logic        clk_gate_on;
    logic        irq;
    engine_evt_t evt;
    engine_cfg_t cfg;
    int          miscompares = 0;
    int          tests_run = 0;

    // Clock toggles every half period of 100 ns.
    always #50 clock = ~clock;

    i2c_channel_regs DUT (.clock(clock), .srst(srst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_in(sda_in),
        .scl_in(scl_in), .debug_mode(debug_mode), .bus_busy_in(busy),
        .sending_in(sending), .evt(evt), .cfg(cfg),
        .clk_gate_on(clk_gate_on), .irq(irq));

    engine_model #(.DLY(3)) partner (.clock(clock), .srst(srst),
        .cfg(cfg), .kick(kick), .rx_data(rx_data), .evt(evt),
        .busy(busy), .sending(sending));

    // ---------------------------------------------------------------
    // Shared tasks.
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic kick_evt(input logic [7:0] k);
        @(posedge clock);
        kick <= k;
        @(posedge clock);
        kick <= 8'h00;
    endtask : kick_evt

    // ---------------------------------------------------------------
    // Test sequence.
    // ---------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (int a = 0; a < 9; a++)
            rd(4'(a), (a == 2) ? {9'h000, BIT_RATE_RESET} : 16'h0000);
        rd(4'hF, 16'h0000);
        $display("test reset values done");
        wr(4'h0, 16'hFFFF); rd(4'h0, 16'h0133);
        wr(4'h1, 16'hFFFF); rd(4'h1, 16'h0006);
        wr(4'h2, 16'hFFFF); rd(4'h2, 16'h007F);
        wr(4'h3, 16'hFFFF); rd(4'h3, 16'h03FF);
        wr(4'h8, 16'hFFFF); rd(4'h8, 16'h00FF);
        wr(4'hF, 16'hFFFF); rd(4'hF, 16'h0000);
        wr(4'h8, 16'h0000);
        settle(2);
        chk({6'h00, cfg.own_address_value}, 16'h03FF);
        chk({14'h0, cfg.wide_address_sel, cfg.general_call_reply}, 16'h0003);
        wr(4'h1, 16'h0000);
        settle(2);
        chk({6'h00, cfg.own_address_value}, 16'h007F);
        chk({14'h0, cfg.wide_address_sel, cfg.general_call_reply}, 16'h0000);
        wr(4'h2, 16'h0055);
        settle(2);
        chk({9'h000, cfg.bit_rate_value}, 16'h0055);
        for (int s = 0; s < 4; s++)
        begin
            wr(4'h0, 16'h0030 | 16'(s));
            settle(2);
            chk({12'h0, cfg.clock_origin_sel, cfg.clock_divide_sel},
                {12'h0, 2'(s), (s % 2 == 1) ? 2'h0 : 2'h3});
        end
        wr(4'h4, 16'h0001);
        wr(4'h2, 16'h0011); rd(4'h2, 16'h0055);
        wr(4'h0, 16'h0000); rd(4'h0, 16'h0033);
        $display("test configuration done");
        settle(6); chk({15'h0, clk_gate_on}, 16'h0001);
        debug_mode <= 1'b1;
        settle(6); chk({15'h0, clk_gate_on}, 16'h0000);
        debug_mode <= 1'b0;
        wr(4'h4, 16'h0000);
        settle(6); chk({15'h0, clk_gate_on}, 16'h0000);
        wr(4'h0, 16'h0100);
        wr(4'h4, 16'h0003);
        debug_mode <= 1'b1;
        settle(6); chk({15'h0, clk_gate_on}, 16'h0001);
        debug_mode <= 1'b0;
        $display("test clock gating done");
        wr(4'h4, 16'h0005); rd(4'h4, 16'h0001);
        wr(4'h4, 16'h0025); rd(4'h4, 16'h0025);
        chk({15'h0, cfg.master_role_sel}, 16'h0001);
        settle(10); rd(4'h4, 16'h0021); rd(4'h7, 16'h0608);
        wr(4'h4, 16'h0029); rd(4'h4, 16'h0029);
        settle(10); rd(4'h4, 16'h0021); rd(4'h7, 16'h0018);
        wr(4'h4, 16'h0031); rd(4'h4, 16'h0031);
        settle(10); rd(4'h4, 16'h0021);
        $display("test requests done");
        wr(4'h7, 16'h0018); rd(4'h7, 16'h0000);
        kick_evt(8'hFC); rd(4'h7, 16'h00FC);
        wr(4'h7, 16'h0000); rd(4'h7, 16'h00FC);
        chk({15'h0, irq}, 16'h0000);
        wr(4'h8, 16'h0004);
        settle(2); chk({15'h0, irq}, 16'h0001);
        wr(4'h7, 16'h0004); rd(4'h7, 16'h00F8);
        chk({15'h0, irq}, 16'h0000);
        wr(4'h7, 16'h00F8); rd(4'h7, 16'h0000);
        rx_data <= 8'hA5;
        kick_evt(8'h03); rd(4'h7, 16'h0003);
        rd(4'h6, 16'h00A5); rd(4'h7, 16'h0001);
        wr(4'h5, 16'h1234); rd(4'h5, 16'h0034);
        rd(4'h7, 16'h0000);
        $display("test flags done");
        kick_evt(8'hFC);
        wr(4'h4, 16'h0023); rd(4'h4, 16'h0023);
        settle(6); rd(4'h4, 16'h0021); rd(4'h7, 16'h0000);
        sda_in <= 1'b0;
        settle(4); rd(4'h7, 16'h1000);
        scl_in <= 1'b0;
        settle(4); rd(4'h7, 16'h1800);
        sda_in <= 1'b1;
        scl_in <= 1'b1;
        $display("test reset and lines done");
        // A write while the clock enable is low must leave no trace.
        clk_en <= 1'b0;
        wr(4'h8, 16'h00AA);
        clk_en <= 1'b1;
        rd(4'h8, 16'h0004);
        $display("test clock enable done");
        close_out();
    end

    // Watchdog: the sequence needs well under a thousand cycles.
    initial
    begin
        #(100 * 3000);
        miscompares++;
        close_out();
    end
endmodule : i2c_channel_register_control_test
